// File: rtl/uir_consts.vh
`ifndef UIR_CONSTS_VH
`define UIR_CONSTS_VH
// register indices on the plain register port
`define UIR_ADDR_MODE 4'h0
`define UIR_ADDR_STAT 4'h1
`define UIR_ADDR_TXD 4'h2
`define UIR_ADDR_RXD 4'h3
`define UIR_ADDR_BRG 4'h4
// serial_mode_register fields
`define UIR_M_EN 15
`define UIR_M_INFRARED_CODEC_ENABLE 12
`define UIR_M_PIN_HI 9
`define UIR_M_PIN_LO 8
`define UIR_M_HIGH_SPEED_BAUD_SELECT 3
`define UIR_M_PDS_HI 2
`define UIR_M_PDS_LO 1
`define UIR_M_STOP_BIT_COUNT_SELECT 0
`define UIR_PIN_IR 2'h3
`define UIR_PDS_ODD 2'h2
// serial_status_register fields
`define UIR_S_BRK 11
`define UIR_S_TXQ_FULL 9
`define UIR_S_TRANSMIT_SHIFT_EMPTY 8
`define UIR_S_PERR 3
`define UIR_S_FERR 2
`define UIR_S_OERR 1
`define UIR_S_RXAV 0
// reset values
`define UIR_MODE_RST 16'h0000
`define UIR_BRG_RST 16'h0000
// oversampling: last phase index and mid-bit sample phase
`define UIR_OS16_LAST 4'hF
`define UIR_OS4_LAST 4'h3
`define UIR_OS16_MID 4'h7
`define UIR_OS4_MID 4'h1
// infrared pulse width in oversample phases, last phase index
`define UIR_IR16_LAST 4'h2
`define UIR_IR4_LAST 4'h0
// frame length without parity and second stop
`define UIR_FRAME_BASE 4'hA
`define UIR_TXQ_DEPTH 16
`define UIR_TXQ_AW 4
`define UIR_TXQ_W 9
`endif

// File: rtl/uir_fifo.v
`timescale 1ns/1ps
module uir_fifo #(
   parameter W = 9,
   parameter D = 16,
   parameter AW = 4
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_valid,
   input wire [W-1:0] i_data,
   output wire o_ready,
   output wire o_valid,
   output wire [W-1:0] o_data,
   input wire i_ready
);
   reg [W-1:0] mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   localparam [AW:0] FULL_CNT = D;
   wire push = i_valid && o_ready;
   wire pop = o_valid && i_ready;
   assign o_ready = (cnt_q != FULL_CNT);
   assign o_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_data = mem_q[rp_q];
   always @(posedge i_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_data;
      end
   end
   always @(posedge i_clk) begin
      if (i_rst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// File: rtl/uir_top.v
`timescale 1ns/1ps
`include "uir_consts.vh"
// Overview of operation
// - with 4x rate and two stops, framing checks the second stop bit.
// - high_speed_baud_select clear gives 16x oversampling, set gives 4x.
// - mode bits 9:8 equal to 11 select the infrared pin configuration.
// - infrared configuration drives a baud clock at the oversampling rate, 16x or 4x, on the baud clock pin.
// - every break request, even back to back, sends a break, never dummy data.
// - a break followed by an ordinary character sends both correctly.
// - data_parity_select 0x selects 8-bit data, usable with the infrared codec.
// - infrared encoder sends every byte unchanged, 80h stays 80h.
// - error interrupt fires for each erroneous byte at its completion.
// - parity and framing flags reflect each received byte's own error state; overrun stays set until cleared.
// - transmit_shift_empty sets only after the last stop bit has left.
module uir_top (
   input wire I_CLK,
   input wire I_SYS_RST,
   input wire [3:0] I_ADDR,
   input wire [15:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [15:0] O_RDATA,
   input wire I_RX,
   output reg O_TX,
   output reg O_BAUD_CLK,
   output reg O_ERR_IRQ,
   output reg O_TXQ_FULL
);
   reg [15:0] mode_q;
   reg [15:0] brg_q;
   reg [15:0] bcnt_q;
   reg brk_req_q;
   reg transmit_shift_empty_q;
   reg tx_busy_q;
   reg [11:0] tx_sh_q;
   reg [3:0] tx_left_q;
   reg [3:0] tx_os_q;
   reg [3:0] ir_hold_q;
   reg rx_line_q;
   reg rx_busy_q;
   reg [3:0] rx_os_q;
   reg [3:0] rx_cnt_q;
   reg [11:0] rx_fr_q;
   reg [7:0] rx_data_q;
   reg rx_avail_q;
   reg perr_q;
   reg ferr_q;
   reg oerr_q;

   wire en = mode_q[`UIR_M_EN];
   wire ir_en = mode_q[`UIR_M_INFRARED_CODEC_ENABLE];
   wire ir_cfg = (mode_q[`UIR_M_PIN_HI:`UIR_M_PIN_LO] == `UIR_PIN_IR);
   wire hs = mode_q[`UIR_M_HIGH_SPEED_BAUD_SELECT];
   wire two_stop = mode_q[`UIR_M_STOP_BIT_COUNT_SELECT];
   wire [1:0] pds = mode_q[`UIR_M_PDS_HI:`UIR_M_PDS_LO];
   // 0x is 8-bit (00 none, 01 even); 10 odd; 11 (9-bit) runs as 8-bit no parity
   wire has_par = pds[1] ^ pds[0];
   wire odd_par = (pds == `UIR_PDS_ODD);
   wire [3:0] os_last = hs ? `UIR_OS4_LAST : `UIR_OS16_LAST;
   wire [3:0] os_mid = hs ? `UIR_OS4_MID : `UIR_OS16_MID;
   wire [3:0] ir_last = hs ? `UIR_IR4_LAST : `UIR_IR16_LAST;
   wire [3:0] nbits = `UIR_FRAME_BASE + {3'h0, has_par} + {3'h0, two_stop};

   wire wr_mode = I_WR && (I_ADDR == `UIR_ADDR_MODE);
   wire wr_stat = I_WR && (I_ADDR == `UIR_ADDR_STAT);
   wire wr_txd = I_WR && (I_ADDR == `UIR_ADDR_TXD);
   wire wr_brg = I_WR && (I_ADDR == `UIR_ADDR_BRG);
   wire rd_rxd = I_RD && (I_ADDR == `UIR_ADDR_RXD);

   // baud tick at the oversampling rate
   wire tick = en && (bcnt_q == brg_q);
   wire half = en && (bcnt_q == {1'b0, brg_q[15:1]});

   always @(posedge I_CLK) begin
      if (I_SYS_RST || !en || tick) begin
         bcnt_q <= 16'h0000;
      end else begin
         bcnt_q <= bcnt_q + 16'h0001;
      end
   end

   // two toggles per oversample tick: one clock period per tick, 16x baud at 16x;
   // runs in idle and receive too, so no external clock source is needed there
   // a divisor of zero merges both toggle points and halves this clock; use one or more
   always @(posedge I_CLK) begin
      if (I_SYS_RST || !ir_cfg) begin
         O_BAUD_CLK <= 1'b0;
      end else if (tick || half) begin
         O_BAUD_CLK <= ~O_BAUD_CLK;
      end
   end

   // transmit queue; bit 8 marks a break request riding with its dummy byte
   wire txq_in_rdy;
   wire txq_valid;
   wire [8:0] txq_data;
   wire tx_last = tx_busy_q && tick && (tx_os_q == os_last) && (tx_left_q == 4'h1);
   wire txq_take = en && (!tx_busy_q || tx_last);
   wire txq_push = wr_txd && txq_in_rdy;

   uir_fifo #(
      .W(`UIR_TXQ_W),
      .D(`UIR_TXQ_DEPTH),
      .AW(`UIR_TXQ_AW)
   ) u_txq (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_valid(wr_txd),
      .i_data({brk_req_q, I_WDATA[7:0]}),
      .o_ready(txq_in_rdy),
      .o_valid(txq_valid),
      .o_data(txq_data),
      .i_ready(txq_take)
   );

   wire [7:0] td = txq_data[7:0];
   wire tpar = odd_par ? ~^td : ^td;
   reg [11:0] tx_frame;
   always @* begin
      if (txq_data[8]) begin
         // parity and stop positions go low too, so a break spans the whole frame
         tx_frame = 12'h000;
      end else if (has_par) begin
         tx_frame = {2'h3, tpar, td, 1'b0};
      end else begin
         tx_frame = {3'h7, td, 1'b0};
      end
   end

   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         tx_busy_q <= 1'b0;
         tx_sh_q <= 12'hFFF;
         tx_left_q <= 4'h0;
         tx_os_q <= 4'h0;
      end else if (!tx_busy_q) begin
         tx_os_q <= 4'h0;
         if (txq_take && txq_valid) begin
            // every queued word is a fresh frame, so breaks never repeat old data
            tx_busy_q <= 1'b1;
            tx_sh_q <= tx_frame;
            tx_left_q <= nbits;
         end
      end else if (tick) begin
         if (tx_os_q == os_last) begin
            tx_os_q <= 4'h0;
            if (tx_last && txq_valid) begin
               // chain the next queued frame so back-to-back frames leave no idle gap
               tx_sh_q <= tx_frame;
               tx_left_q <= nbits;
            end else begin
               tx_sh_q <= {1'b1, tx_sh_q[11:1]};
               tx_left_q <= tx_left_q - 4'h1;
               if (tx_left_q == 4'h1) begin
                  tx_busy_q <= 1'b0;
               end
            end
         end else begin
            tx_os_q <= tx_os_q + 4'h1;
         end
      end
   end

   // shift empty only once the final stop period has fully elapsed
   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         transmit_shift_empty_q <= 1'b1;
      end else begin
         transmit_shift_empty_q <= !tx_busy_q && !txq_valid && !txq_push;
      end
   end

   // infrared encoder: a short high pulse per zero bit; data path is not touched
   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         O_TX <= 1'b1;
      end else if (ir_en) begin
         O_TX <= tx_busy_q && !tx_sh_q[0] && (tx_os_q <= ir_last);
      end else begin
         O_TX <= !tx_busy_q || tx_sh_q[0];
      end
   end

   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         O_TXQ_FULL <= 1'b0;
      end else begin
         O_TXQ_FULL <= !txq_in_rdy;
      end
   end

   // infrared decoder: a pulse reads as zero for the rest of that bit time
   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         ir_hold_q <= 4'h0;
      end else if (ir_en && I_RX) begin
         ir_hold_q <= os_last;
      end else if (tick && ir_hold_q != 4'h0) begin
         ir_hold_q <= ir_hold_q - 4'h1;
      end
   end

   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_line_q <= 1'b1;
      end else if (ir_en) begin
         rx_line_q <= !I_RX && (ir_hold_q == 4'h0);
      end else begin
         rx_line_q <= I_RX;
      end
   end

   wire rx_samp = rx_busy_q && tick && (rx_os_q == os_mid);
   wire rx_done = rx_samp && (rx_cnt_q == nbits - 4'h1);
   wire [7:0] rd8 = rx_fr_q[8:1];
   wire rpar_bad = has_par && (rx_fr_q[9] != (odd_par ? ~^rd8 : ^rd8));
   // the last sampled bit is the second stop when two are configured
   wire fr_bad = !rx_line_q;
   wire ov_now = rx_avail_q && !rd_rxd;

   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_busy_q <= 1'b0;
         rx_os_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         rx_fr_q <= 12'h000;
      end else if (!en) begin
         // disabling mid-frame abandons the byte instead of freezing the receiver
         rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
         rx_os_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         if (en && !rx_line_q) begin
            rx_busy_q <= 1'b1;
            rx_fr_q <= 12'h000;
         end
      end else if (tick) begin
         rx_os_q <= (rx_os_q == os_last) ? 4'h0 : rx_os_q + 4'h1;
         if (rx_samp) begin
            rx_fr_q[rx_cnt_q] <= rx_line_q;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            // a start bit gone high at mid-bit was a glitch
            if (rx_done || (rx_cnt_q == 4'h0 && rx_line_q)) begin
               rx_busy_q <= 1'b0;
            end
         end
      end
   end

   // per-byte flags: parity and framing follow every completed byte
   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_data_q <= 8'h00;
         rx_avail_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         oerr_q <= 1'b0;
         O_ERR_IRQ <= 1'b0;
      end else begin
         O_ERR_IRQ <= rx_done && (rpar_bad || fr_bad || ov_now);
         if (rx_done) begin
            perr_q <= rpar_bad;
            ferr_q <= fr_bad;
         end
         // on overrun the unread byte is kept; the newcomer only updates the flags
         if (rx_done && !ov_now) begin
            rx_data_q <= rd8;
         end
         if (rx_done) begin
            rx_avail_q <= 1'b1;
         end else if (rd_rxd) begin
            rx_avail_q <= 1'b0;
         end
         // a new overrun beats a software clear in the same cycle
         if (rx_done && ov_now) begin
            oerr_q <= 1'b1;
         end else if (wr_stat && !I_WDATA[`UIR_S_OERR]) begin
            oerr_q <= 1'b0;
         end
      end
   end

   always @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         mode_q <= `UIR_MODE_RST;
         brg_q <= `UIR_BRG_RST;
         brk_req_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_q <= I_WDATA;
         end
         if (wr_brg) begin
            brg_q <= I_WDATA;
         end
         // request stands until the next data write carries it as a break
         if (wr_stat && I_WDATA[`UIR_S_BRK]) begin
            brk_req_q <= 1'b1;
         end else if (txq_push) begin
            brk_req_q <= 1'b0;
         end
      end
   end

   reg [15:0] stat_w;
   always @* begin
      stat_w = 16'h0000;
      stat_w[`UIR_S_BRK] = brk_req_q;
      stat_w[`UIR_S_TXQ_FULL] = !txq_in_rdy;
      stat_w[`UIR_S_TRANSMIT_SHIFT_EMPTY] = transmit_shift_empty_q;
      stat_w[`UIR_S_PERR] = perr_q;
      stat_w[`UIR_S_FERR] = ferr_q;
      stat_w[`UIR_S_OERR] = oerr_q;
      stat_w[`UIR_S_RXAV] = rx_avail_q;
   end

   always @(posedge I_CLK) begin
      if (I_SYS_RST || !I_RD) begin
         O_RDATA <= 16'h0000;
      end else begin
         case (I_ADDR)
            `UIR_ADDR_MODE: begin
               O_RDATA <= mode_q;
            end
            `UIR_ADDR_STAT: begin
               O_RDATA <= stat_w;
            end
            `UIR_ADDR_RXD: begin
               O_RDATA <= {8'h00, rx_data_q};
            end
            `UIR_ADDR_BRG: begin
               O_RDATA <= brg_q;
            end
            default: begin
               O_RDATA <= 16'h0000;
            end
         endcase
      end
   end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
`include "uir_consts.vh"
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] addr = 4'h0;
   reg [15:0] wdata = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg ir_quiet = 1'b0;
   wire [15:0] rdata;
   wire rx, tx, bclk, irq, full;
   integer miscompares = 0;
   integer checks_done = 0;
   integer irq_seen = 0;
   integer i;
   reg [9:0] fr;
   uir_top i_uir_top (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX(rx), .O_TX(tx), .O_BAUD_CLK(bclk),
      .O_ERR_IRQ(irq), .O_TXQ_FULL(full));
   uir_remote i_uir_remote (.i_clk(clk), .i_ir(ir_quiet), .o_rx(rx));
   always #2 clk = ~clk;
   always @(negedge clk) if (irq === 1'b1) irq_seen = irq_seen + 1;
   task complete_run;
      begin
         if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task check(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
         end
      end
   endtask
   // idle cycle after the strobe so two calls never drive wr twice in one step
   task wreg(input [3:0] a, input [15:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rchk(input [3:0] a, input [15:0] m, input [15:0] e);
      begin
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 check(rdata & m, e);
         @(posedge clk);
      end
   endtask
   // aligns on the start bit, then one window of os clocks per bit
   task catch_tx(input integer nb, input integer os, input ir);
      integer w, c, hi;
      begin
         c = 0;
         #1;
         while (tx !== ir && c < 5000) begin
            @(negedge clk);
            c = c + 1;
         end
         check({15'h0000, c < 5000}, 16'h0001);
         fr = 10'h000;
         for (w = 0; w < nb; w = w + 1) begin
            hi = 0;
            repeat (os) begin
               hi = hi + tx;
               @(negedge clk);
            end
            fr[w] = ir ? (hi == 0) : (hi * 2 > os);
         end
      end
   endtask
   task count_bclk(input integer e);
      integer r;
      reg p;
      begin
         r = 0;
         @(negedge clk);
         p = bclk;
         repeat (64) begin
            @(negedge clk);
            r = r + (bclk & !p);
            p = bclk;
         end
         check(r[15:0], e[15:0]);
      end
   endtask
   task t_reset;
      begin
         rchk(`UIR_ADDR_MODE, 16'hFFFF, `UIR_MODE_RST);
         rchk(`UIR_ADDR_STAT, 16'hFFFF, 16'h0100);
         wreg(4'hF, 16'hFFFF);
         rchk(4'hF, 16'hFFFF, 16'h0000);
         rchk(`UIR_ADDR_MODE, 16'hFFFF, 16'h0000);
      end
   endtask
   task t_tx16;
      begin
         wreg(`UIR_ADDR_MODE, 16'h8000);
         wreg(`UIR_ADDR_TXD, 16'h00A5);
         catch_tx(9, 16, 1'b0);
         check({6'h00, fr}, 16'h014A);
         repeat (4) @(posedge clk);
         rchk(`UIR_ADDR_STAT, 16'h0100, 16'h0000);
         repeat (16) @(posedge clk);
         rchk(`UIR_ADDR_STAT, 16'h0100, 16'h0100);
      end
   endtask
   task t_rx4;
      begin
         wreg(`UIR_ADDR_MODE, 16'h8009);
         i_uir_remote.send(8'h3C, 2'b10, 4);
         rchk(`UIR_ADDR_STAT, 16'h000F, 16'h0001);
         rchk(`UIR_ADDR_RXD, 16'hFFFF, 16'h003C);
         i = irq_seen;
         wreg(`UIR_ADDR_MODE, 16'h800A);
         i_uir_remote.send(8'h5A, 2'b11, 4);
         i_uir_remote.send(8'hC3, 2'b11, 4);
         repeat (4) @(posedge clk);
         check(irq_seen[15:0] - i[15:0], 16'h0002);
         rchk(`UIR_ADDR_STAT, 16'h000F, 16'h000B);
         rchk(`UIR_ADDR_RXD, 16'hFFFF, 16'h005A);
         wreg(`UIR_ADDR_STAT, 16'h0000);
         wreg(`UIR_ADDR_MODE, 16'h8009);
         i = irq_seen;
         i_uir_remote.send(8'h96, 2'b01, 4);
         rchk(`UIR_ADDR_STAT, 16'h000F, 16'h0005);
         rchk(`UIR_ADDR_RXD, 16'hFFFF, 16'h0096);
         check(irq_seen[15:0] - i[15:0], 16'h0001);
      end
   endtask
   task t_brk;
      begin
         wreg(`UIR_ADDR_MODE, 16'h8000);
         for (i = 0; i < 3; i = i + 1) begin
            if (i < 2)
               wreg(`UIR_ADDR_STAT, 16'h0800);
            wreg(`UIR_ADDR_TXD, (i < 2) ? 16'h0055 : 16'h0080);
            catch_tx(10, 16, 1'b0);
            check({6'h00, fr}, (i < 2) ? 16'h0000 : 16'h0300);
            repeat (20) @(negedge clk);
            check({15'h0000, tx}, 16'h0001);
         end
      end
   endtask
   task t_fifo;
      begin
         wreg(`UIR_ADDR_MODE, 16'h0008);
         for (i = 0; i < 17; i = i + 1)
            wreg(`UIR_ADDR_TXD, 16'h0010 + i[15:0]);
         check({15'h0000, full}, 16'h0001);
         rchk(`UIR_ADDR_STAT, 16'h0200, 16'h0200);
         wreg(`UIR_ADDR_MODE, 16'h8008);
         for (i = 0; i < 16; i = i + 1) begin
            catch_tx(10, 4, 1'b0);
            check({6'h00, fr}, {7'h01, i[7:0] + 8'h10, 1'b0});
         end
         repeat (40) @(negedge clk);
         check({15'h0000, tx}, 16'h0001);
         rchk(`UIR_ADDR_STAT, 16'h0300, 16'h0100);
      end
   endtask
   task t_ir;
      begin
         wreg(`UIR_ADDR_BRG, 16'h0001);
         ir_quiet <= 1'b1;
         for (i = 0; i < 2; i = i + 1) begin
            wreg(`UIR_ADDR_MODE, 16'h9300 | {14'h0000, i[0], 1'b0});
            count_bclk(32);
            wreg(`UIR_ADDR_TXD, 16'h0080);
            catch_tx(9, 32, 1'b1);
            check({6'h00, fr}, 16'h0100);
            repeat (140) @(posedge clk);
         end
         ir_quiet <= 1'b0;
         wreg(`UIR_ADDR_MODE, 16'h8000);
         count_bclk(0);
      end
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      miscompares = miscompares + 1;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_tx16;
      t_rx4;
      t_brk;
      t_fifo;
      t_ir;
      complete_run;
   end
endmodule

// File: test/uir_assertions.sv
`timescale 1ns/1ps
`include "uir_consts.vh"
module uir_checker (
   input wire I_CLK,
   input wire I_SYS_RST,
   input wire [3:0] I_ADDR,
   input wire [15:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [15:0] O_RDATA,
   input wire I_RX,
   input wire O_TX,
   input wire O_BAUD_CLK,
   input wire O_ERR_IRQ,
   input wire O_TXQ_FULL
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   reset_idle_a: assert property ($fell(I_SYS_RST) |-> O_TX && !O_ERR_IRQ && !O_TXQ_FULL)
      else $error("line not idle after reset");
   read_window_a: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
      else $error("read data outside its cycle");
   irq_spacing_a: assert property (O_ERR_IRQ |=> !O_ERR_IRQ [*8])
      else $error("error pulse too long or too close");
   low_hold_a: assert property ($fell(O_TX) |-> !O_TX [*3])
      else $error("line low for too short a time");
   full_cause_a: assert property ($rose(O_TXQ_FULL) |->
      $past(I_WR) || $past(I_WR, 2) || $past(I_WR, 3))
      else $error("queue full without a write");
   full_hold_a: assert property ($rose(O_TXQ_FULL) |-> O_TXQ_FULL [*4])
      else $error("queue full dropped early");
   baud_on_a: assert property (I_WR && I_ADDR == `UIR_ADDR_MODE && I_WDATA[15]
      && I_WDATA[9:8] == 2'h3 |-> ##[2:40] $rose(O_BAUD_CLK))
      else $error("baud clock missing");
   baud_off_a: assert property (I_WR && I_ADDR == `UIR_ADDR_MODE && I_WDATA[9:8] != 2'h3
      |-> ##3 !O_BAUD_CLK [*4])
      else $error("baud clock outside infrared setup");
   cover property (O_ERR_IRQ);
   cover property ($rose(O_TXQ_FULL));
   cover property ($rose(O_BAUD_CLK));
endmodule
bind uir_top uir_checker i_uir_checker (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RX(I_RX), .O_TX(O_TX),
   .O_BAUD_CLK(O_BAUD_CLK), .O_ERR_IRQ(O_ERR_IRQ), .O_TXQ_FULL(O_TXQ_FULL));

// File: test/uir_remote.sv
`timescale 1ns/1ps
module uir_remote (
   input wire i_clk,
   input wire i_ir,
   output wire o_rx
);
   reg line_q;
   initial line_q = 1'b1;
   // an infrared transceiver idles low; frames are sent in wired mode only
   assign o_rx = i_ir ? 1'b0 : line_q;
   // the two trailing bits are free so a caller can corrupt stop or parity
   task send(input [7:0] b, input [1:0] tl, input integer os);
      reg [10:0] f;
      integer k;
      begin
         f = {tl, b, 1'b0};
         for (k = 0; k < 11 * os; k = k + 1) begin
            line_q <= f[k / os];
            @(posedge i_clk);
         end
         line_q <= 1'b1;
         @(posedge i_clk);
      end
   endtask
endmodule
